//--- design/adc_clock_reset_pkg.sv
package adc_clock_reset_pkg;

    // Register offsets on the control port
    localparam logic [7:0] REG_DEVICE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REG_PLL_SETUP            = 8'h01;

    // Field positions in device_control_reset
    localparam int CTL_SOFT_RESET_BIT = 7;
    localparam int CTL_RATE_BAND_LSB  = 4;
    localparam int CTL_PLL_ENABLE_BIT = 0;

    // Field positions in pll_setup
    localparam int PLL_LOCK_BIT       = 7;
    localparam int PLL_SOURCE_BIT     = 4;
    localparam int PLL_RATIO_LSB      = 0;

    // Values after reset
    localparam logic [7:0] CTL_RESET_VALUE = 8'h00;
    localparam logic [7:0] PLL_RESET_VALUE = 8'h01;

    // Ratio codes and their base multipliers at 32, 44.1 and 48 kHz
    localparam logic [2:0] RATIO_128 = 3'h0;
    localparam logic [2:0] RATIO_256 = 3'h1;
    localparam logic [2:0] RATIO_384 = 3'h2;
    localparam logic [2:0] RATIO_512 = 3'h3;
    localparam logic [2:0] RATIO_768 = 3'h4;
    localparam int RATIO_W = 10;

    // Sample rate bands: base, 96 kHz (halved), 192 kHz (quartered)
    localparam logic [1:0] BAND_48  = 2'h0;
    localparam logic [1:0] BAND_96  = 2'h1;
    localparam logic [1:0] BAND_192 = 2'h2;

    // Clock rate and time figures
    localparam longint CLK_HZ        = 200000000;
    localparam longint FRAME_MIN_HZ  = 32000;
    localparam longint FRAME_MAX_HZ  = 192000;
    localparam longint SOFT_RESET_NS = 100;

    // Longest frame period rounds up, shortest rounds down
    localparam int FRAME_LONG_CYCLES  = int'((CLK_HZ + FRAME_MIN_HZ - 1) / FRAME_MIN_HZ);
    localparam int FRAME_SHORT_CYCLES = int'(CLK_HZ / FRAME_MAX_HZ);
    localparam int SOFT_RESET_CYCLES  = int'((SOFT_RESET_NS * CLK_HZ + 999999999)
                                              / 1000000000);

endpackage

//--- design/adc_pll_clock_and_reset_control.sv
// Contract
// RQ1: Source bit in pll_setup picks master clock pin or frame clock as reference.
// RQ2: Frame clock reference accepted for sample rates 32 kHz to 192 kHz.
// RQ3: Host programs ratio field to match the frequency on the master clock pin.
// RQ4: Codes 0..4 give 128..768 times fs; halved at 96, quartered at 192 kHz.
// RQ5: Read-only lock flag in bit 7 of pll_setup reports PLL lock.
// RQ6: Host reads lock flag after power-up before unmuting outputs.
// RQ7: Frame clock reference only valid with serial port in slave mode.
// RQ8: Host disables PLL, reprograms, then re-enables when changing settings.
// RQ9: Core regulator off while reset pin low, on once pin high.
// RQ10: Reference output off in reset, on only after pin is driven high.
// RQ11: Core held in reset until core supply reaches 1.2 V release point.
// RQ12: Monitor hysteresis: release at 1.2 V pin high, reassert below 0.6 V pin low.
// RQ13: Host waits one charge time constant after reset before control traffic.
// RQ14: Hardware reset pulse holds pin low for the full discharge time.
// RQ15: Writing bit 7 of offset zero resets the device.
// RQ16: Software reset restores register defaults and clears itself when done.
`timescale 1ns/1ps

module adc_pll_clock_and_reset_control
    import adc_clock_reset_pkg::*;
#(
    parameter int FRAME_LONG  = FRAME_LONG_CYCLES,
    parameter int FRAME_SHORT = FRAME_SHORT_CYCLES
)
(
    // Clock and reset
    input  logic                clk,
    input  logic                reset,
    // Pins and analog monitors
    input  logic                powerdown_reset_n,
    input  logic                core_supply_above_release,
    input  logic                core_supply_below_trip,
    input  logic                frame_clock_pin,
    input  logic                pll_lock_raw,
    // Serial port configuration, same clock
    input  logic                serial_port_slave,
    // Register port from the control interface
    input  logic [7:0]          reg_addr,
    input  logic [7:0]          reg_wdata,
    input  logic                reg_write,
    input  logic                reg_read,
    output logic [7:0]          reg_rdata,
    // Analog and core controls
    output logic                regulator_enable,
    output logic                reference_enable,
    output logic                core_reset,
    output logic                pll_enable,
    output logic                pll_source_frame,
    output logic [RATIO_W-1:0]  pll_ratio,
    output logic                frame_rate_ok
);

    localparam int CNT_W = $clog2(FRAME_LONG + 2);
    localparam int SR_W  = $clog2(SOFT_RESET_CYCLES + 1);

    // Refuse period bounds that leave no usable rate window
    if (FRAME_SHORT < 2 || FRAME_LONG <= FRAME_SHORT)
    begin : g_bounds_bad
        $error("frame period bounds unusable");
    end

    typedef enum logic [3:0] {
        ST_OFF    = 4'b0001,
        ST_CHARGE = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_SOFT   = 4'b1000
    } power_state_t;

    // Multiplier from ratio code and sample rate band
    function automatic logic [RATIO_W-1:0] ratio_of(input logic [2:0] code,
                                                    input logic [1:0] band);
        logic [RATIO_W-1:0] base;
        base = '0;
        unique case (code)
            RATIO_128: base = 10'd128;
            RATIO_256: base = 10'd256;
            RATIO_384: base = 10'd384;
            RATIO_512: base = 10'd512;
            RATIO_768: base = 10'd768;
            default:   base = '0;
        endcase
        if (band == BAND_96)
            ratio_of = base >> 1;
        else if (band == BAND_192)
            ratio_of = base >> 2;
        else
            ratio_of = base;
    endfunction

    // Two-stage synchronisers for pins
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end
        else
        begin
            sync1_q <= {powerdown_reset_n, core_supply_above_release,
                        core_supply_below_trip, frame_clock_pin, pll_lock_raw};
            sync2_q <= sync1_q;
        end
    end

    logic pin_high;
    logic supply_up;
    logic supply_down;
    logic frame_s;
    logic lock_s;
    assign {pin_high, supply_up, supply_down, frame_s, lock_s} = sync2_q;

    // Power and reset sequencing state
    power_state_t       state_q;
    power_state_t       state_d;
    logic [SR_W-1:0]    sr_cnt_q;
    logic [SR_W-1:0]    sr_cnt_d;
    logic               soft_req;

    always_comb
    begin
        state_d  = state_q;
        sr_cnt_d = sr_cnt_q;
        unique case (state_q)
            ST_OFF:
            begin
                if (pin_high)
                    state_d = ST_CHARGE;
            end
            ST_CHARGE:
            begin
                if (!pin_high && supply_down)
                    state_d = ST_OFF;
                else if (pin_high && supply_up)            // RQ11
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (!pin_high && supply_down)              // RQ12
                    state_d = ST_OFF;
                else if (soft_req)                         // RQ15
                begin
                    state_d  = ST_SOFT;
                    sr_cnt_d = SR_W'(SOFT_RESET_CYCLES);
                end
            end
            ST_SOFT:
            begin
                if (!pin_high && supply_down)
                    state_d = ST_OFF;
                else if (sr_cnt_q <= SR_W'(1))             // RQ16
                    state_d = ST_RUN;
                else
                    sr_cnt_d = sr_cnt_q - SR_W'(1);
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q  <= ST_OFF;
            sr_cnt_q <= '0;
        end
        else
        begin
            state_q  <= state_d;
            sr_cnt_q <= sr_cnt_d;
        end
    end

    // Frame clock period measurement
    logic             frame_prev_q;
    logic [CNT_W-1:0] frame_cnt_q;
    logic [CNT_W-1:0] frame_cnt_d;
    logic             frame_ok_q;
    logic             frame_ok_d;

    always_comb
    begin
        frame_cnt_d = frame_cnt_q;
        frame_ok_d  = frame_ok_q;
        if (frame_s && !frame_prev_q)
        begin
            frame_ok_d  = (frame_cnt_q >= CNT_W'(FRAME_SHORT))
                       && (frame_cnt_q <= CNT_W'(FRAME_LONG));   // RQ2
            frame_cnt_d = CNT_W'(1);
        end
        else if (frame_cnt_q > CNT_W'(FRAME_LONG))
            frame_ok_d  = 1'b0;                                  // RQ2
        else
            frame_cnt_d = frame_cnt_q + CNT_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            frame_prev_q <= 1'b0;
            frame_cnt_q  <= '0;
            frame_ok_q   <= 1'b0;
        end
        else
        begin
            frame_prev_q <= frame_s;
            frame_cnt_q  <= frame_cnt_d;
            frame_ok_q   <= frame_ok_d;
        end
    end

    // Control registers and read port
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] pll_q;
    logic [7:0] pll_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       lock_flag;
    logic       core_live;

    assign core_live = (state_q == ST_RUN);
    assign soft_req  = reg_write && (reg_addr == REG_DEVICE_CONTROL_RESET)
                    && reg_wdata[CTL_SOFT_RESET_BIT];

    always_comb
    begin
        ctl_d   = ctl_q;
        pll_d   = pll_q;
        rdata_d = rdata_q;
        if (!core_live)
        begin
            ctl_d = CTL_RESET_VALUE;                       // RQ16
            pll_d = PLL_RESET_VALUE;                       // RQ16
        end
        else if (reg_write && !soft_req)
        begin
            if (reg_addr == REG_DEVICE_CONTROL_RESET)
                ctl_d = reg_wdata & 8'h31;
            else if (reg_addr == REG_PLL_SETUP)
                pll_d = reg_wdata & 8'h17;                 // RQ1
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                REG_DEVICE_CONTROL_RESET:
                    rdata_d = {(state_q == ST_SOFT), ctl_q[6:0]};
                REG_PLL_SETUP:
                    rdata_d = {lock_flag, pll_q[6:0]};     // RQ5
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctl_q   <= CTL_RESET_VALUE;
            pll_q   <= PLL_RESET_VALUE;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctl_q   <= ctl_d;
            pll_q   <= pll_d;
            rdata_q <= rdata_d;
        end
    end

    // Output controls
    logic               ref_legal;
    logic               src_frame;
    logic               pll_run_d;
    logic [RATIO_W-1:0] ratio_d;
    logic               reg_en_q;
    logic               vref_en_q;
    logic               core_rst_q;
    logic               pll_run_q;
    logic               src_frame_q;
    logic [RATIO_W-1:0] ratio_q;
    logic               lock_q;

    assign src_frame = pll_q[PLL_SOURCE_BIT];                                  // RQ1
    assign ref_legal = src_frame ? (serial_port_slave && frame_ok_q) : 1'b1;   // RQ7
    assign pll_run_d = core_live && ctl_q[CTL_PLL_ENABLE_BIT] && ref_legal;
    assign ratio_d   = ratio_of(pll_q[PLL_RATIO_LSB +: 3], ctl_q[CTL_RATE_BAND_LSB +: 2]); // RQ4
    assign lock_flag = lock_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reg_en_q    <= 1'b0;
            vref_en_q   <= 1'b0;
            core_rst_q  <= 1'b1;
            pll_run_q   <= 1'b0;
            src_frame_q <= 1'b0;
            ratio_q     <= '0;
            lock_q      <= 1'b0;
        end
        else
        begin
            reg_en_q    <= pin_high;                       // RQ9
            vref_en_q   <= pin_high;                       // RQ10
            core_rst_q  <= !core_live;                     // RQ11
            pll_run_q   <= pll_run_d;
            src_frame_q <= src_frame;
            ratio_q     <= ratio_d;
            lock_q      <= pll_run_q && lock_s;            // RQ5
        end
    end

    assign reg_rdata        = rdata_q;
    assign regulator_enable = reg_en_q;
    assign reference_enable = vref_en_q;
    assign core_reset       = core_rst_q;
    assign pll_enable       = pll_run_q;
    assign pll_source_frame = src_frame_q;
    assign pll_ratio        = ratio_q;
    assign frame_rate_ok    = frame_ok_q;

endmodule

//--- verification/clock_reset_properties.sv
`timescale 1ns/1ps

module clock_reset_properties
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Pins and monitors
    input wire logic       powerdown_reset_n,
    input wire logic       core_supply_above_release,
    input wire logic       core_supply_below_trip,
    input wire logic       serial_port_slave,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Controls
    input wire logic       regulator_enable,
    input wire logic       reference_enable,
    input wire logic       core_reset,
    input wire logic       pll_enable,
    input wire logic       pll_source_frame,
    input wire logic       frame_rate_ok
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // No trip and no write in this cycle
    logic quiet;
    logic soft_go;
    assign quiet   = !core_supply_below_trip && !reg_write;
    assign soft_go = reg_write && reg_addr == 8'h00 && reg_wdata[7] && !core_reset;

    regulator_gate_a: assert property (regulator_enable |-> $past(powerdown_reset_n, 3))
        else $error("regulator on without pin high");
    reference_gate_a: assert property (reference_enable |-> $past(powerdown_reset_n, 3))
        else $error("reference on without pin high");
    core_release_a: assert property ($fell(core_reset) |-> $past(core_supply_above_release, 4))
        else $error("core left reset below release level");
    trip_hysteresis_a: assert property ((quiet [*5]) ##0 !core_reset |=> !core_reset)
        else $error("core reset without supply trip");
    soft_reset_len_a: assert property (soft_go |-> ##2 core_reset [*8]
        ##1 core_reset [*8] ##1 core_reset [*4] ##1 !core_reset)
        else $error("soft reset length wrong");
    lock_idle_a: assert property (reg_read && reg_addr == 8'h01 && !pll_enable
        && !$past(pll_enable) |=> !reg_rdata[7]) else $error("lock flag with pll off");
    frame_source_a: assert property (pll_enable && pll_source_frame
        && $past(pll_source_frame) |-> $past(serial_port_slave) && $past(frame_rate_ok))
        else $error("pll ran on frame clock without slave or rate");
    pll_in_run_a: assert property (pll_enable |-> !core_reset)
        else $error("pll running with core in reset");
endmodule

bind adc_pll_clock_and_reset_control clock_reset_properties u_props
(
    .clk(clk), .reset(reset), .powerdown_reset_n(powerdown_reset_n),
    .core_supply_above_release(core_supply_above_release),
    .core_supply_below_trip(core_supply_below_trip), .serial_port_slave(serial_port_slave),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .regulator_enable(regulator_enable),
    .reference_enable(reference_enable), .core_reset(core_reset), .pll_enable(pll_enable),
    .pll_source_frame(pll_source_frame), .frame_rate_ok(frame_rate_ok)
);

//--- verification/clock_supply_model.sv
`timescale 1ns/1ps

module clock_supply_model #(parameter int CHARGE = 40)
(
    // Clock and controls
    input wire logic       clk,
    input wire logic       regulator_enable,
    input wire logic       pll_enable,
    input wire logic [7:0] half_period,
    // Pins and monitors
    output logic           frame_clock_pin,
    output logic           above_release,
    output logic           below_trip,
    output logic           pll_lock_raw
);
    int level = 0;
    int ph = 0;
    int lk = 0;
    initial frame_clock_pin = 1'b0;

    // Supply charge, frame clock phase, lock delay; frame clock stands still at zero
    always @(posedge clk)
    begin
        if (regulator_enable === 1'b1 && level < CHARGE) level <= level + 1;
        else if (regulator_enable !== 1'b1 && level > 0) level <= level - 1;
        ph <= (half_period == 8'h00 || ph + 1 >= half_period) ? 0 : ph + 1;
        if (half_period == 8'h00) frame_clock_pin <= 1'b0;
        else if (ph + 1 >= half_period) frame_clock_pin <= !frame_clock_pin;
        lk <= (pll_enable === 1'b1) ? (lk < 10 ? lk + 1 : lk) : 0;
    end

    // Comparator levels at two thirds and one third of full charge
    assign above_release = level >= 2 * CHARGE / 3;
    assign below_trip    = level < CHARGE / 3;
    assign pll_lock_raw  = lk >= 10;
endmodule

//--- verification/tb_adc_pll_clock_and_reset_control.sv
`timescale 1ns/1ps

module tb_adc_pll_clock_and_reset_control
    import adc_clock_reset_pkg::*;
;
    logic               clk = 1'b0, reset = 1'b1, powerdown_reset_n = 1'b0;
    logic               serial_port_slave = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]         reg_addr = 8'h00, reg_wdata = 8'h00, half = 8'h00, d, reg_rdata;
    logic               above, below, frame, lock, reg_en, ref_en, core_reset, pll_en, src, ok;
    logic [RATIO_W-1:0] pll_ratio;
    int                 n_mismatch = 0, checks_done = 0, i;

    // Clock
    always #2.5 clk = !clk;

    adc_pll_clock_and_reset_control #(.FRAME_LONG(60), .FRAME_SHORT(10)) uut
    (
        .clk(clk), .reset(reset), .powerdown_reset_n(powerdown_reset_n),
        .core_supply_above_release(above), .core_supply_below_trip(below),
        .frame_clock_pin(frame), .pll_lock_raw(lock), .serial_port_slave(serial_port_slave),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .regulator_enable(reg_en),
        .reference_enable(ref_en), .core_reset(core_reset), .pll_enable(pll_en),
        .pll_source_frame(src), .pll_ratio(pll_ratio), .frame_rate_ok(ok)
    );
    clock_supply_model model
    (
        .clk(clk), .regulator_enable(reg_en), .pll_enable(pll_en), .half_period(half),
        .frame_clock_pin(frame), .above_release(above), .below_trip(below), .pll_lock_raw(lock)
    );

    // Verdict and end of run
    task complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task step();
        @(posedge clk);
        #1;
    endtask
    task chk(input logic good);
        checks_done++;
        if (good !== 1'b1)
        begin
            n_mismatch++;
            $display("ERROR %0t compare failed", $time);
        end
    endtask
    task hold(input logic good);
        if (good !== 1'b1)
        begin
            n_mismatch++;
            $display("ERROR %0t wait ran out", $time);
            complete_run();
        end
    endtask
    // Register cycles, one idle edge before each strobe
    task wr(input logic [7:0] a, input logic [7:0] v);
        step();
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        step();
        reg_write = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        step();
        reg_addr = a;
        reg_read = 1'b1;
        step();
        reg_read = 1'b0;
        d = reg_rdata;
    endtask

    // Power-up order and register defaults
    task t_power();
        repeat (8) step();
        chk(reg_en === 1'b0 && ref_en === 1'b0 && core_reset === 1'b1);
        powerdown_reset_n = 1'b1;
        repeat (6) step();
        chk(reg_en === 1'b1 && ref_en === 1'b1 && core_reset === 1'b1);
        for (i = 0; i < 200 && core_reset !== 1'b0; i++) step();
        hold(core_reset === 1'b0);
        chk(above === 1'b1);
        rd(REG_DEVICE_CONTROL_RESET);
        chk(d === CTL_RESET_VALUE);
        rd(REG_PLL_SETUP);
        chk(d === PLL_RESET_VALUE);
    endtask
    // Every ratio code in every rate band
    task t_ratio();
        logic [RATIO_W-1:0] base [5] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300};
        for (int b = 0; b < 3; b++)
            for (int c = 0; c < 8; c++)
            begin
                wr(REG_DEVICE_CONTROL_RESET, 8'(b << CTL_RATE_BAND_LSB));
                wr(REG_PLL_SETUP, 8'(c));
                repeat (3) step();
                chk(pll_ratio === (c < 5 ? base[c] >> b : '0));
            end
    endtask
    // Reference choice, slave mode, frame rate window, lock flag
    task t_pll();
        half = 8'h0f;
        wr(REG_PLL_SETUP, 8'h11);
        wr(REG_DEVICE_CONTROL_RESET, 8'h01);
        repeat (150) step();
        chk(ok === 1'b1 && src === 1'b1 && pll_en === 1'b0);
        serial_port_slave = 1'b1;
        repeat (20) step();
        rd(REG_PLL_SETUP);
        chk(pll_en === 1'b1 && d === 8'h91);
        half = 8'h03;
        repeat (150) step();
        chk(ok === 1'b0 && pll_en === 1'b0);
        half = 8'h0f;
        repeat (100) step();
        chk(ok === 1'b1 && pll_en === 1'b1);
        half = 8'h00;
        repeat (100) step();
        chk(ok === 1'b0 && pll_en === 1'b0);
        wr(REG_DEVICE_CONTROL_RESET, 8'h00);
        wr(REG_PLL_SETUP, 8'h01);
        wr(REG_DEVICE_CONTROL_RESET, 8'h01);
        repeat (20) step();
        rd(REG_PLL_SETUP);
        chk(pll_en === 1'b1 && src === 1'b0 && d === 8'h81);
        wr(REG_DEVICE_CONTROL_RESET, 8'h00);
        repeat (3) step();
        rd(REG_PLL_SETUP);
        chk(d[7] === 1'b0);
    endtask
    // Unmapped place, then soft reset back to defaults
    task t_soft();
        wr(REG_DEVICE_CONTROL_RESET, 8'h20);
        wr(REG_PLL_SETUP, 8'h13);
        wr(8'h05, 8'hff);
        rd(8'h05);
        chk(d === 8'h00);
        wr(REG_DEVICE_CONTROL_RESET, 8'h80);
        rd(REG_DEVICE_CONTROL_RESET);
        chk(d[7] === 1'b1 && core_reset === 1'b1);
        for (i = 0; i < 60 && core_reset !== 1'b0; i++) step();
        hold(core_reset === 1'b0);
        rd(REG_DEVICE_CONTROL_RESET);
        chk(d === CTL_RESET_VALUE);
        rd(REG_PLL_SETUP);
        chk(d === PLL_RESET_VALUE);
    endtask
    // Pin low keeps the core running until the supply trips
    task t_hyst();
        powerdown_reset_n = 1'b0;
        repeat (6) step();
        chk(reg_en === 1'b0 && ref_en === 1'b0 && core_reset === 1'b0);
        for (i = 0; i < 200 && below !== 1'b1; i++) step();
        hold(below === 1'b1);
        repeat (6) step();
        chk(core_reset === 1'b1);
    endtask

    // Main sequence
    initial
    begin
        repeat (16) step();
        reset = 1'b0;
        t_power();
        t_ratio();
        t_pll();
        t_soft();
        t_hyst();
        complete_run();
    end
endmodule
